// [design/lfs_pkg.sv]
// Shared constants and types for the link frame supervisor
package lfs_pkg;

  // Link and unit counts
  localparam int NUM_LINKS = 4;
  localparam int NUM_UNITS = 4;
  localparam int UNIT_IDX_W = 2;
  localparam int CNT_W = 16;

  // Bit-level framing
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [2:0] ONES_FLAG = 3'h6;
  localparam logic [2:0] ONES_SAT = 3'h7;
  localparam logic [2:0] DLY_FULL = 3'h7;
  localparam int BITS_W = 12;
  localparam int BYTES_W = BITS_W - 3;
  localparam logic [BYTES_W-1:0] MIN_FRAME_BYTES = 9'h004;
  localparam logic [BYTES_W-1:0] MAX_FRAME_BYTES = 9'h104;

  // Frame check sequence, reflected 16-bit polynomial
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;

  // Concentrator queue
  localparam int Q_DEPTH = 32;
  localparam int Q_BYTES_W = 14;
  localparam int MAX_QUEUE_MS = 120;
  localparam int UPLINK_KBPS = 64;
  localparam int Q_HIGH_PCT = 70;
  localparam logic [Q_BYTES_W-1:0] Q_LIMIT_BYTES =
    Q_BYTES_W'(MAX_QUEUE_MS * UPLINK_KBPS / 8);
  localparam logic [Q_BYTES_W-1:0] Q_HIGH_BYTES =
    Q_BYTES_W'(MAX_QUEUE_MS * UPLINK_KBPS / 8 * Q_HIGH_PCT / 100);

  typedef enum logic [0:0] {
    RX_HUNT,
    RX_FRAME
  } lfs_rx_state_e;

  // One serial link sample from the line interface
  typedef struct packed {
    logic strobe;
    logic data;
    logic lost;
  } lfs_rx_line_s;

  // One queued uplink message descriptor
  typedef struct packed {
    logic fault;
    logic [8:0] len;
    logic [7:0] handle;
  } lfs_msg_s;

  localparam int MSG_W = $bits(lfs_msg_s);

endpackage

// [design/lfs_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;

  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;
  wire [PW-1:0] wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + PW'(1);
  wire [PW-1:0] rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + PW'(1);

  assign in_ready = cnt_reg != FULL_CNT;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign level = cnt_reg;

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_next;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_next;
      end
      cnt_reg <= cnt_reg + CW'(do_wr) - CW'(do_rd);
    end
  end
endmodule
`default_nettype wire

// [design/lfs_top.sv]
// Link frame supervisor: receive frame classification and uplink queue watch
//
// Overview of operation
// - Each supervised link keeps its own aborted-frame and erroneous-frame counters.
// - A frame that ends in an abort sequence instead of a closing flag counts as aborted.
// - A frame whose 16-bit check sequence does not verify counts as erroneous.
// - A frame of fewer than four bytes counts as erroneous.
// - A frame longer than 260 bytes counts as erroneous.
// - A frame whose bit count between flags is not a multiple of eight counts as erroneous.
// - A frame that lost data for want of a buffer or a failed memory access counts as erroneous.
// - Both ends of each link use flag-delimited, bit-stuffed framing with a check sequence.
// - Uplink messages from several radio units merge into one queue toward the controller.
// - Once the queue time is exceeded, each insertion removes the oldest queued message unless that message is a fault report.
// - A fault is raised when queue occupancy passes seventy percent of its capacity.
// - A fault is raised whenever a message is discarded for queue overflow.
// - Messages that carry fault reports are never chosen for removal.
// - Queue time is the queued byte total over the uplink rate.
// - The queue time limit is 120 ms, which is 960 bytes at 64 kbit/s.
`timescale 1ns/1ps
`default_nettype none
module lfs_top
  import lfs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire lfs_rx_line_s [NUM_LINKS-1:0] rx_line,
  output logic [NUM_LINKS-1:0] abort_pulse,
  output logic [NUM_LINKS-1:0] error_pulse,
  output logic [NUM_LINKS-1:0][CNT_W-1:0] abort_count,
  output logic [NUM_LINKS-1:0][CNT_W-1:0] error_count,
  output logic [NUM_LINKS-1:0] frame_ok_pulse,
  input wire lfs_msg_s [NUM_UNITS-1:0] unit_msg,
  input wire logic [NUM_UNITS-1:0] unit_valid,
  output logic [NUM_UNITS-1:0] unit_ready,
  output lfs_msg_s up_msg,
  output logic up_valid,
  input wire logic up_ready,
  output logic [Q_BYTES_W-1:0] queue_bytes,
  output logic queue_high,
  output logic queue_over_time,
  output logic queue_high_pulse,
  output logic queue_drop_pulse,
  output logic [CNT_W-1:0] queue_high_count,
  output logic [CNT_W-1:0] queue_drop_count
);

  // Receive supervision, one instance per link
  genvar g;
  generate
    for (g = 0; g < NUM_LINKS; g++) begin : g_link
      lfs_rx_state_e st_reg;
      lfs_rx_state_e st_next;
      logic [2:0] ones_reg;
      logic [6:0] dly_reg;
      logic [2:0] dly_cnt_reg;
      logic [15:0] crc_reg;
      logic [BITS_W-1:0] bits_reg;
      logic lost_reg;
      logic abort_pulse_reg;
      logic error_pulse_reg;
      logic ok_pulse_reg;
      logic [CNT_W-1:0] abort_cnt_reg;
      logic [CNT_W-1:0] error_cnt_reg;

      // Line symbol decode
      wire stb = rx_line[g].strobe;
      wire din = rx_line[g].data;
      wire in_frame = st_reg == RX_FRAME;
      wire is_abort = stb & din & (ones_reg == ONES_FLAG);
      wire is_flag = stb & ~din & (ones_reg == ONES_FLAG);
      wire is_stuff = stb & ~din & (ones_reg == ONES_STUFF);
      wire is_data = stb & ~is_abort & ~is_flag & ~is_stuff;
      // The last seven data bits may be the head of a flag, so commit through a delay
      wire commit = is_data & in_frame & (dly_cnt_reg == DLY_FULL);
      // Check sequence step on the oldest delayed bit
      wire crc_fb = crc_reg[0] ^ dly_reg[6];
      wire [15:0] crc_upd = {1'b0, crc_reg[15:1]} ^ (crc_fb ? CRC_POLY : 16'h0000);
      wire [BYTES_W-1:0] nbytes = bits_reg[BITS_W-1:3];
      wire has_body = bits_reg != '0;
      wire bits_sat = &bits_reg;
      wire [2:0] ones_inc = (ones_reg == ONES_SAT) ? ONES_SAT : ones_reg + 3'h1;
      wire frame_end = is_flag & in_frame & has_body;

      // Frame classification at the closing flag
      wire crc_bad = crc_reg != CRC_GOOD;
      wire too_short = nbytes < MIN_FRAME_BYTES;
      wire too_long = nbytes > MAX_FRAME_BYTES;
      wire not_aligned = bits_reg[2:0] != 3'h0;
      wire lost_now = lost_reg | rx_line[g].lost;
      wire frame_bad = crc_bad | too_short | too_long | not_aligned | lost_now;
      wire abort_hit = is_abort & in_frame & (has_body | dly_cnt_reg == DLY_FULL);

      // Hunt for a flag, fall back to hunting on abort
      always_comb begin
        st_next = st_reg;
        case (st_reg)
          RX_HUNT: begin
            if (is_flag) begin
              st_next = RX_FRAME;
            end
          end
          RX_FRAME: begin
            if (is_abort) begin
              st_next = RX_HUNT;
            end
          end
          default: begin
            st_next = RX_HUNT;
          end
        endcase
      end

      // Receiver state and run of consecutive ones
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          st_reg <= RX_HUNT;
          ones_reg <= '0;
        end else begin
          st_reg <= st_next;
          if (stb) begin
            ones_reg <= din ? ones_inc : 3'h0;
          end
        end
      end

      // Delay line, check sequence and body length
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          dly_reg <= '0;
          dly_cnt_reg <= '0;
          crc_reg <= CRC_INIT;
          bits_reg <= '0;
          lost_reg <= 1'b0;
        end else if (is_flag || is_abort) begin
          dly_reg <= '0;
          dly_cnt_reg <= '0;
          crc_reg <= CRC_INIT;
          bits_reg <= '0;
          lost_reg <= 1'b0;
        end else begin
          if (is_data) begin
            dly_reg <= {dly_reg[5:0], din};
            if (dly_cnt_reg != DLY_FULL) begin
              dly_cnt_reg <= dly_cnt_reg + 3'h1;
            end
          end
          if (commit) begin
            crc_reg <= crc_upd;
            if (!bits_sat) begin
              bits_reg <= bits_reg + BITS_W'(1);
            end
          end
          if (rx_line[g].lost && in_frame) begin
            lost_reg <= 1'b1;
          end
        end
      end

      // Per-link event pulses and counters
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          abort_pulse_reg <= 1'b0;
          error_pulse_reg <= 1'b0;
          ok_pulse_reg <= 1'b0;
          abort_cnt_reg <= '0;
          error_cnt_reg <= '0;
        end else begin
          abort_pulse_reg <= abort_hit;
          error_pulse_reg <= frame_end & frame_bad;
          ok_pulse_reg <= frame_end & ~frame_bad;
          if (abort_hit) begin
            abort_cnt_reg <= abort_cnt_reg + CNT_W'(1);
          end
          if (frame_end && frame_bad) begin
            error_cnt_reg <= error_cnt_reg + CNT_W'(1);
          end
        end
      end

      // Per-link outputs
      assign abort_pulse[g] = abort_pulse_reg;
      assign error_pulse[g] = error_pulse_reg;
      assign frame_ok_pulse[g] = ok_pulse_reg;
      assign abort_count[g] = abort_cnt_reg;
      assign error_count[g] = error_cnt_reg;
    end
  endgenerate

  // Round-robin merge of unit messages into the queue
  logic [UNIT_IDX_W-1:0] rr_reg;
  logic [UNIT_IDX_W-1:0] grant_idx;
  logic grant_any;
  logic [UNIT_IDX_W-1:0] probe;

  // The unit at the pointer has first claim, then upward
  always_comb begin
    grant_idx = rr_reg;
    grant_any = 1'b0;
    probe = '0;
    for (int k = NUM_UNITS - 1; k >= 0; k--) begin
      probe = rr_reg + UNIT_IDX_W'(k);
      if (unit_valid[probe]) begin
        grant_idx = probe;
        grant_any = 1'b1;
      end
    end
  end

  // Queue head and handshake
  lfs_msg_s head;
  logic head_valid;
  logic fifo_in_ready;
  logic pop;

  // Only the granted unit sees ready
  wire push = grant_any & fifo_in_ready;
  wire lfs_msg_s push_msg = unit_msg[grant_idx];
  wire [UNIT_IDX_W-1:0] rr_next = grant_idx + UNIT_IDX_W'(1);

  assign unit_ready = push ? (NUM_UNITS'(1) << grant_idx) : '0;

  // Concentrator queue of message descriptors
  lfs_fifo #(
    .WIDTH(MSG_W),
    .DEPTH(Q_DEPTH)
  ) u_queue (
    .mclk(mclk),
    .reset(reset),
    .in_data(push_msg),
    .in_valid(grant_any),
    .in_ready(fifo_in_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(pop),
    .level()
  );

  // Queue time watch, counted in bytes at the uplink rate
  logic [Q_BYTES_W-1:0] bytes_reg;
  logic high_reg;
  logic high_pulse_reg;
  logic drop_pulse_reg;
  logic [CNT_W-1:0] high_cnt_reg;
  logic [CNT_W-1:0] drop_cnt_reg;

  // A fault-report head shields the queue from discards
  wire over_time = bytes_reg > Q_LIMIT_BYTES;
  wire drop = push & over_time & head_valid & ~head.fault;
  wire [Q_BYTES_W-1:0] add_bytes = push ? Q_BYTES_W'(push_msg.len) : '0;
  wire [Q_BYTES_W-1:0] sub_bytes = pop ? Q_BYTES_W'(head.len) : '0;
  wire [Q_BYTES_W-1:0] bytes_next = bytes_reg + add_bytes - sub_bytes;
  wire high_next = bytes_next > Q_HIGH_BYTES;

  // A dropped head is hidden from the uplink
  assign up_valid = head_valid & ~drop;
  assign up_msg = head;
  assign pop = drop | (up_valid & up_ready);
  assign queue_bytes = bytes_reg;
  assign queue_high = high_reg;
  assign queue_over_time = over_time;
  assign queue_high_pulse = high_pulse_reg;
  assign queue_drop_pulse = drop_pulse_reg;
  assign queue_high_count = high_cnt_reg;
  assign queue_drop_count = drop_cnt_reg;

  // Arbiter pointer, byte total and threshold level
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rr_reg <= '0;
      bytes_reg <= '0;
      high_reg <= 1'b0;
    end else begin
      if (push) begin
        rr_reg <= rr_next;
      end
      bytes_reg <= bytes_next;
      high_reg <= high_next;
    end
  end

  // Threshold and overflow fault pulses and counters
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      high_pulse_reg <= 1'b0;
      drop_pulse_reg <= 1'b0;
      high_cnt_reg <= '0;
      drop_cnt_reg <= '0;
    end else begin
      high_pulse_reg <= high_next & ~high_reg;
      drop_pulse_reg <= drop;
      if (high_next && !high_reg) begin
        high_cnt_reg <= high_cnt_reg + CNT_W'(1);
      end
      if (drop) begin
        drop_cnt_reg <= drop_cnt_reg + CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// [sim/lfs_assertions.sv]
// Port checker for the link frame supervisor
`timescale 1ns/1ps
`default_nettype none
module lfs_checker
  import lfs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [NUM_LINKS-1:0] abort_pulse,
  input wire logic [NUM_LINKS-1:0] error_pulse,
  input wire logic [NUM_LINKS-1:0][CNT_W-1:0] abort_count,
  input wire logic [NUM_LINKS-1:0][CNT_W-1:0] error_count,
  input wire logic [NUM_LINKS-1:0] frame_ok_pulse,
  input wire logic [NUM_UNITS-1:0] unit_valid,
  input wire logic [NUM_UNITS-1:0] unit_ready,
  input wire lfs_msg_s up_msg,
  input wire logic [Q_BYTES_W-1:0] queue_bytes,
  input wire logic queue_high,
  input wire logic queue_over_time,
  input wire logic queue_high_pulse,
  input wire logic queue_drop_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_abc; abort_pulse[0] |-> abort_count[0] == $past(abort_count[0]) + 16'h0001; endproperty
  a_abc: assert property (p_abc) else $error("abort count step");
  property p_erc; error_pulse[1] |-> error_count[1] == $past(error_count[1]) + 16'h0001; endproperty
  a_erc: assert property (p_erc) else $error("error count step");
  property p_erh; !error_pulse[1] |-> $stable(error_count[1]); endproperty
  a_erh: assert property (p_erh) else $error("error count moved");
  property p_ab1; abort_pulse[0] |=> !abort_pulse[0] [*3]; endproperty
  a_ab1: assert property (p_ab1) else $error("abort pulse long");
  property p_okx; frame_ok_pulse[0] |-> !error_pulse[0]; endproperty
  a_okx: assert property (p_okx) else $error("good and bad frame");
  property p_ovr; queue_over_time == (queue_bytes > Q_LIMIT_BYTES); endproperty
  a_ovr: assert property (p_ovr) else $error("queue time flag");
  property p_hi; $rose(queue_high) |-> queue_high_pulse && queue_bytes > Q_HIGH_BYTES; endproperty
  a_hi: assert property (p_hi) else $error("queue high fault");
  property p_drp;
    queue_drop_pulse |-> $past(|(unit_valid & unit_ready) && queue_over_time && !up_msg.fault);
  endproperty
  a_drp: assert property (p_drp) else $error("drop without cause");
  property p_one; $onehot0(unit_ready); endproperty
  a_one: assert property (p_one) else $error("two grants");
  c_abort: cover property (abort_pulse[0]);
  c_drop: cover property (queue_drop_pulse);
  c_full: cover property (|unit_valid && unit_ready == '0);
endmodule
`default_nettype wire

// [sim/lfs_uplink_sink.sv]
// Uplink side model that takes queue heads promptly, slowly or not at all
`timescale 1ns/1ps
`default_nettype none
module lfs_uplink_sink (
  input wire logic mclk,
  input wire logic [1:0] mode,
  output logic up_ready
);
  logic [1:0] div = 2'h0;
  initial up_ready = 1'b0;
  // Mode 0 stalls, 1 takes every cycle, 2 takes one cycle in four
  always @(negedge mclk) begin
    div <= div + 2'h1;
    up_ready <= mode == 2'h1 || (mode == 2'h2 && div == 2'h0);
  end
endmodule
`default_nettype wire

// [sim/link_frame_supervisor_tb.sv]
// Testbench for the link frame supervisor
`timescale 1ns/1ps
`default_nettype none
module link_frame_supervisor_tb
  import lfs_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, lz = 1'b0, up_ready, t;
  lfs_rx_line_s [NUM_LINKS-1:0] rx_line = '0;
  lfs_msg_s [NUM_UNITS-1:0] unit_msg = '0;
  logic [NUM_UNITS-1:0] unit_valid = '0, unit_ready;
  logic [1:0] mode = 2'h0;
  logic [NUM_LINKS-1:0] abort_pulse, error_pulse, frame_ok_pulse;
  logic [NUM_LINKS-1:0][CNT_W-1:0] abort_count, error_count;
  lfs_msg_s up_msg;
  logic up_valid, queue_high, queue_over_time, queue_high_pulse, queue_drop_pulse;
  logic [Q_BYTES_W-1:0] queue_bytes;
  logic [CNT_W-1:0] queue_high_count, queue_drop_count;
  int fail_count = 0, tests_run = 0, seed = 32'h38584393, ones = 0, mb = 0, ed = 0, eh = 0;
  int ea[NUM_LINKS] = '{0, 0, 0, 0}, ee[NUM_LINKS] = '{0, 0, 0, 0};
  int sa[NUM_LINKS] = '{0, 0, 0, 0}, se[NUM_LINKS] = '{0, 0, 0, 0};
  int ns[8] = '{2, 1, 258, 259, 10, 10, 10, 40};
  bit hi = 0;
  int sd = 0, sh = 0;
  int so[NUM_LINKS] = '{0, 0, 0, 0}, eo[NUM_LINKS] = '{0, 0, 0, 0};
  lfs_msg_s q[$];
  lfs_top dut (.mclk, .reset, .rx_line, .abort_pulse, .error_pulse, .abort_count,
    .error_count, .frame_ok_pulse, .unit_msg, .unit_valid, .unit_ready, .up_msg, .up_valid,
    .up_ready, .queue_bytes, .queue_high, .queue_over_time, .queue_high_pulse,
    .queue_drop_pulse, .queue_high_count, .queue_drop_count);
  lfs_uplink_sink sink (.mclk, .mode, .up_ready);
  always #50 mclk = ~mclk;
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Queue model: pops, drops of the oldest entry and inserts
  always @(posedge mclk) begin
    for (int i = 0; i < NUM_LINKS; i++) begin
      sa[i] += abort_pulse[i];
      se[i] += error_pulse[i];
      so[i] += frame_ok_pulse[i];
    end
    sd += queue_drop_pulse;
    sh += queue_high_pulse;
    if (!reset && |(unit_valid & unit_ready) && mb > 960 && !q[0].fault) begin
      chk("up_valid", up_valid, 1'b0);
      mb -= q[0].len;
      void'(q.pop_front());
      ed++;
    end else if (!reset && up_valid && up_ready) begin
      chk("up_msg", up_msg, q[0]);
      mb -= q[0].len;
      void'(q.pop_front());
    end
    if (!reset && |(unit_valid & unit_ready)) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (unit_valid[u] && unit_ready[u]) begin
          q.push_back(unit_msg[u]);
          mb += unit_msg[u].len;
        end
      end
    end
    if (mb > 672 && !hi) eh++;
    hi = mb > 672;
  end
  task automatic bit1(input int l, input logic b);
    @(negedge mclk);
    rx_line[l] = {1'b1, b, lz};
    lz = 1'b0;
  endtask
  task automatic sb(input int l, input logic b);
    bit1(l, b);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin
      bit1(l, 1'b0);
      ones = 0;
    end
  endtask
  task automatic flag(input int l);
    for (int i = 0; i < 8; i++) bit1(l, i != 0 && i != 7);
    ones = 0;
  endtask
  task automatic settle(input int l);
    @(negedge mclk);
    rx_line[l] = '0;
    repeat (3) @(negedge mclk);
    chk("abort_count", abort_count[l], ea[l]);
    chk("abort_pulses", sa[l], ea[l]);
    chk("error_count", error_count[l], ee[l]);
    chk("error_pulses", se[l], ee[l]);
    chk("ok_pulses", so[l], eo[l]);
  endtask
  task automatic frame(input int l, input int n, input logic bad, input int xb, input logic lost);
    logic [15:0] crc, fcs;
    logic [7:0] d;
    logic e;
    crc = CRC_INIT;
    fcs = 16'h0000;
    flag(l);
    for (int i = 0; i < n + 2; i++) begin
      if (i == n) fcs = ~crc ^ {15'h0000, bad};
      d = i < n ? 8'($random(seed)) : (i == n ? fcs[7:0] : fcs[15:8]);
      lz = lost && i == 1;
      for (int k = 0; k < 8; k++) begin
        sb(l, d[k]);
        if (i < n) crc = (crc >> 1) ^ ((crc[0] ^ d[k]) ? CRC_POLY : 16'h0000);
      end
    end
    for (int k = 0; k < xb; k++) sb(l, 1'b0);
    flag(l);
    e = bad || n + 2 < 4 || n + 2 > 260 || xb != 0 || lost;
    ee[l] += int'(e);
    eo[l] += int'(!e);
    settle(l);
  endtask
  task automatic abort_frame(input int l);
    flag(l);
    for (int i = 0; i < 16; i++) sb(l, 1'(i % 3));
    for (int i = 0; i < 7; i++) bit1(l, 1'b1);
    ea[l]++;
    settle(l);
  endtask
  task automatic push(input int u, input logic f, input int len, input int w, output logic ok);
    int k;
    k = 0;
    @(negedge mclk);
    unit_msg[u] = {f, 9'(len), 8'($random(seed))};
    unit_valid[u] = 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (!unit_ready[u] && k < w);
    ok = unit_ready[u];
    @(negedge mclk);
    unit_valid[u] = 1'b0;
  endtask
  task automatic drain(input logic [1:0] m);
    mode = m;
    for (int k = 0; k < 2000 && (up_valid || q.size() != 0); k++) @(negedge mclk);
    mode = 2'h0;
    chk("queue_bytes", queue_bytes, mb);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) frame(i % 4, ns[i], i == 4, i == 5 ? 3 : 0, i == 6);
    abort_frame(0);
    abort_frame(2);
    frame(0, 6, 1'b0, 0, 1'b0);
    for (int i = 0; i < 32; i++) push(i % 4, 1'b0, 20, 60, t);
    push(1, 1'b0, 20, 4, t);
    chk("refused", t, 1'b0);
    drain(2'h2);
    for (int i = 0; i < 12; i++) push(i % 4, i == 2, i == 2 ? 400 : 100, 60, t);
    chk("queue_bytes", queue_bytes, mb);
    chk("queue_high", queue_high, mb > 672);
    chk("queue_over_time", queue_over_time, mb > 960);
    drain(2'h1);
    chk("drop_count", queue_drop_count, ed);
    chk("high_count", queue_high_count, eh);
    chk("drop_pulses", sd, ed);
    chk("high_pulses", sh, eh);
    complete_run;
  end
  initial begin
    #(100 * 30000);
    fail_count++;
    complete_run;
  end
endmodule
bind lfs_top lfs_checker chk_i (.mclk, .reset, .abort_pulse, .error_pulse, .abort_count,
  .error_count, .frame_ok_pulse, .unit_valid, .unit_ready, .up_msg, .queue_bytes,
  .queue_high, .queue_over_time, .queue_high_pulse, .queue_drop_pulse);
`default_nettype wire
